/* src/drvsp_filter.sv */
module drvsp_filter (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Synchronised overload level
  input wire logic ovl,
  // Persistent overload
  output logic trip
);

  localparam logic [drvsp_pkg::FILT_W-1:0] LIMIT =
    drvsp_pkg::FILT_W'(drvsp_pkg::OVL_DELAY_CYC);

  logic [drvsp_pkg::FILT_W-1:0] cnt;
  logic [drvsp_pkg::FILT_W-1:0] next_cnt;
  logic next_trip;

  // Count consecutive overload cycles, saturating at the limit
  always_comb begin
    next_cnt = cnt;
    if (!ovl) begin
      next_cnt = '0;
    end else if (cnt != LIMIT) begin
      next_cnt = cnt + 1'b1;
    end
    next_trip = (next_cnt == LIMIT);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= '0;
      trip <= 1'b0;
    end else begin
      cnt <= next_cnt;
      trip <= next_trip;
    end
  end

  chk_filter_time: assert property (@(posedge clk) disable iff (!nrst)
    trip |-> cnt == LIMIT) else $error("overload tripped before filter delay");

  chk_filter_release: assert property (@(posedge clk) disable iff (!nrst)
    !ovl |=> !trip) else $error("overload trip survived a quiet cycle");

endmodule

/* src/drvsp_pkg.sv */
package drvsp_pkg;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam int FRAME_BITS = 16;
  localparam int CHANNELS = 8;
  localparam int CMD_BITS = 2;
  localparam int DIAG_D_POS = 0;
  localparam int DIAG_OL_POS = 1;
  localparam int CNT_W = 5;
  localparam logic [4:0] CNT_MIN_OK = 5'h10;
  localparam logic [4:0] CNT_WRAP_TOP = 5'h17;
  localparam logic [4:0] CNT_WRAP_BASE = 5'h10;
  localparam logic [2:0] CNT_WORD_MASK = 3'h0;

  // ****************************************
  // Channel commands
  // ****************************************
  localparam logic [1:0] CMD_STANDBY = 2'h0;
  localparam logic [1:0] CMD_INPUT = 2'h1;
  localparam logic [1:0] CMD_ON = 2'h2;
  localparam logic [1:0] CMD_OFF = 2'h3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] IN_REG_RESET = 16'hFFFF;
  localparam logic FLAG_RESET = 1'b1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int OVL_DELAY_NS = 3000;
  localparam int OVL_DELAY_CYC = (OVL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_W = 9;
  localparam int SYNC_W = 3 + 3 * CHANNELS;

endpackage

/* src/drvsp_port.sv */
// Functional notes
// - Frames are sixteen-bit words, most significant bit first, both ways.
// - Incoming frame holds two command bits per output channel.
// - Outgoing frame holds two fault status bits per channel.
// - Overload switches the channel off, latched until cleared by serial command; limp-home exit also clears the latch.
// - Overload acts only after persisting at least three microseconds.
// - Limp-home ignores commands but keeps protection and fault readout.
// - Count clocks under select; flag error if not multiple of eight or below sixteen.
// - Error flag shows on serial output from select fall to first rising clock.
// - Error flag also set on undervoltage exit, limp-home exit, low-quiescent exit.
// - A frame of valid length clears the error flag.
// - In flag window output is flag OR serial input, then shift data.
// - Select fall alone, without clocks, reads the error flag.
// - Serial input is sampled on each falling clock edge.
// - Serial output changes on each rising clock edge.
// - Latch received data only for lengths multiple of eight, sixteen minimum.
// - Length counter starts at select fall and advances on rising clock.
// - First sixteen bits out are diagnostics, then shifted-in bits follow.
// - Frames of sixteen bits plus any number of eight-bit words are accepted.
// - Clock and input activity is ignored while select is high.
// - Flag appears right after select fall: zero good, one error or mode exit.
module drvsp_port (
  // System clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Mode inputs
  input wire logic limp_home_input,
  input wire logic uvlo_lock,
  input wire logic low_quiescent_state,
  // Raw fault sense
  input wire logic [7:0] overload_raw,
  input wire logic [7:0] over_temp_raw,
  input wire logic [7:0] open_load_raw,
  // Device state
  output logic [15:0] input_word,
  output logic [7:0] drive_on,
  output logic [7:0] channel_shutdown,
  output logic [15:0] fault_word,
  output logic frame_error_flag
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic frame_len_ok(input logic [drvsp_pkg::CNT_W-1:0] c);
    frame_len_ok = (c >= drvsp_pkg::CNT_MIN_OK) &&
      (c[2:0] == drvsp_pkg::CNT_WORD_MASK);
  endfunction

  function automatic logic [1:0] chan_cmd(input logic [15:0] w, input int ch);
    chan_cmd = w[ch * drvsp_pkg::CMD_BITS +: drvsp_pkg::CMD_BITS];
  endfunction

  // ****************************************
  // Link domain: bit counter
  // ****************************************
  logic [drvsp_pkg::CNT_W-1:0] cnt;
  logic [drvsp_pkg::CNT_W-1:0] next_cnt;

  // Once sixteen is reached only the position within an eight-bit word matters
  always_comb begin
    if (cnt == drvsp_pkg::CNT_WRAP_TOP) begin
      next_cnt = drvsp_pkg::CNT_WRAP_BASE;
    end else begin
      next_cnt = cnt + 1'b1;
    end
  end

  // Held clear while select is high
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // ****************************************
  // Link domain: receive shifter
  // ****************************************
  logic [15:0] rx;
  logic [15:0] next_rx;

  always_comb begin
    next_rx = rx;
    if (!cs_n) begin
      next_rx = {rx[14:0], si};
    end
  end

  always_ff @(negedge sclk or negedge nrst) begin
    if (!nrst) begin
      rx <= '0;
    end else begin
      rx <= next_rx;
    end
  end

  // ****************************************
  // Link domain: transmit shifter and frame status
  // ****************************************
  logic [14:0] tx;
  logic [14:0] next_tx;
  logic so_q;
  logic next_so_q;
  logic frame_ok;
  logic next_frame_ok;
  logic start_tog;
  logic next_start_tog;
  logic [15:0] diag_snap;

  always_comb begin
    next_tx = tx;
    next_so_q = so_q;
    next_frame_ok = frame_ok;
    next_start_tog = start_tog;
    if (!cs_n) begin
      next_frame_ok = frame_len_ok(next_cnt);
      if (cnt == '0) begin
        next_so_q = diag_snap[15];
        next_tx = diag_snap[14:0];
        next_start_tog = !start_tog;
      end else begin
        // Shifted-in bits trail the diagnostic word by sixteen clocks
        next_so_q = tx[14];
        next_tx = {tx[13:0], rx[0]};
      end
    end
  end

  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      tx <= '0;
      so_q <= 1'b0;
      frame_ok <= 1'b0;
      start_tog <= 1'b0;
    end else begin
      tx <= next_tx;
      so_q <= next_so_q;
      frame_ok <= next_frame_ok;
      start_tog <= next_start_tog;
    end
  end

  // Flag window before the first rising clock; zero clocks still shows the flag
  always_comb begin
    so_oe = !cs_n;
    if (cnt == '0) begin
      so = frame_error_flag | si;
    end else begin
      so = so_q;
    end
  end

  // ****************************************
  // System domain: input synchronisers
  // ****************************************
  logic [drvsp_pkg::SYNC_W-1:0] sync_q;
  logic cs_act_s;
  logic start_tog_s;
  logic limp_s;
  logic [7:0] ovl_s;
  logic [7:0] ot_s;
  logic [7:0] ol_s;
  logic [7:0] trip;

  drvsp_sync #(.WIDTH(drvsp_pkg::SYNC_W)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({!cs_n, start_tog, limp_home_input, overload_raw, over_temp_raw, open_load_raw}),
    .q(sync_q)
  );

  always_comb begin
    {cs_act_s, start_tog_s, limp_s, ovl_s, ot_s, ol_s} = sync_q;
  end

  genvar gi;
  generate
    for (gi = 0; gi < drvsp_pkg::CHANNELS; gi++) begin : g_filt
      drvsp_filter u_filt (
        .clk(clk),
        .nrst(nrst),
        .ovl(ovl_s[gi]),
        .trip(trip[gi])
      );
    end
  endgenerate

  // ****************************************
  // System domain: frame end, modes and flag
  // ****************************************
  logic cs_act_d;
  logic seen_tog;
  logic limp_d;
  logic uvlo_d;
  logic lowq_d;
  logic frame_end;
  logic frame_valid;
  logic mode_exit;
  logic limp_exit;
  logic next_seen_tog;
  logic next_flag;
  logic [15:0] next_input_word;
  logic [15:0] next_diag_snap;

  always_comb begin
    frame_end = cs_act_d && !cs_act_s;
    // Link words are still when select rises because the clock rests low
    frame_valid = (start_tog_s != seen_tog) && frame_ok;
    limp_exit = limp_d && !limp_s;
    mode_exit = (uvlo_d && !uvlo_lock) || limp_exit ||
      (lowq_d && !low_quiescent_state);
    next_seen_tog = frame_end ? start_tog_s : seen_tog;
    next_flag = frame_error_flag;
    if (frame_end && frame_valid) begin
      next_flag = 1'b0;
    end
    if ((frame_end && !frame_valid) || mode_exit) begin
      next_flag = 1'b1;
    end
    next_input_word = input_word;
    if (limp_exit) begin
      next_input_word = drvsp_pkg::IN_REG_RESET;
    end else if (frame_end && frame_valid && !limp_s) begin
      next_input_word = rx;
    end
    // Snapshot frozen for the whole frame
    next_diag_snap = cs_act_s ? diag_snap : fault_word;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cs_act_d <= 1'b0;
      seen_tog <= 1'b0;
      limp_d <= 1'b0;
      uvlo_d <= 1'b0;
      lowq_d <= 1'b0;
      frame_error_flag <= drvsp_pkg::FLAG_RESET;
      input_word <= drvsp_pkg::IN_REG_RESET;
      diag_snap <= '0;
    end else begin
      cs_act_d <= cs_act_s;
      seen_tog <= next_seen_tog;
      limp_d <= limp_s;
      uvlo_d <= uvlo_lock;
      lowq_d <= low_quiescent_state;
      frame_error_flag <= next_flag;
      input_word <= next_input_word;
      diag_snap <= next_diag_snap;
    end
  end

  // ****************************************
  // System domain: fault latches and drive
  // ****************************************
  logic [7:0] d_fault;
  logic [7:0] ol_fault;
  logic [7:0] next_d_fault;
  logic [7:0] next_ol_fault;
  logic [7:0] next_drive_on;
  logic [15:0] next_fault_word;
  logic [7:0] clr;

  always_comb begin
    for (int i = 0; i < drvsp_pkg::CHANNELS; i++) begin
      clr[i] = limp_exit || (next_input_word != input_word &&
        chan_cmd(next_input_word, i) == drvsp_pkg::CMD_STANDBY);
      // A new fault wins over a clear in the same cycle
      next_d_fault[i] = trip[i] || ot_s[i] || (d_fault[i] && !clr[i]);
      next_ol_fault[i] = ol_s[i] || (ol_fault[i] && !clr[i]);
      next_drive_on[i] = !limp_s && !next_d_fault[i] &&
        chan_cmd(next_input_word, i) == drvsp_pkg::CMD_ON;
      next_fault_word[2 * i + drvsp_pkg::DIAG_D_POS] = next_d_fault[i];
      next_fault_word[2 * i + drvsp_pkg::DIAG_OL_POS] = next_ol_fault[i];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      d_fault <= '0;
      ol_fault <= '0;
      drive_on <= '0;
      fault_word <= '0;
    end else begin
      d_fault <= next_d_fault;
      ol_fault <= next_ol_fault;
      drive_on <= next_drive_on;
      fault_word <= next_fault_word;
    end
  end

  always_comb begin
    channel_shutdown = d_fault;
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_valid_latch: assert property (@(posedge clk) disable iff (!nrst)
    frame_end && frame_valid && !limp_s && !limp_exit |=> input_word == $past(rx))
    else $error("valid frame not latched");

  chk_bad_frame_kept: assert property (@(posedge clk) disable iff (!nrst)
    frame_end && !frame_valid && !limp_exit |=> $stable(input_word))
    else $error("invalid frame changed input register");

  chk_bad_frame_flag: assert property (@(posedge clk) disable iff (!nrst)
    frame_end && !frame_valid |=> frame_error_flag)
    else $error("invalid frame did not set error flag");

  chk_flag_cleared: assert property (@(posedge clk) disable iff (!nrst)
    frame_end && frame_valid && !mode_exit |=> !frame_error_flag)
    else $error("valid frame did not clear error flag");

  chk_mode_exit: assert property (@(posedge clk) disable iff (!nrst)
    $fell(low_quiescent_state) || $fell(uvlo_lock) |-> ##1 frame_error_flag)
    else $error("mode exit did not set error flag");

  chk_limp_ignore: assert property (@(posedge clk) disable iff (!nrst)
    limp_s && limp_d && frame_end |=> $stable(input_word))
    else $error("command taken in limp home");

  chk_overload_off: assert property (@(posedge clk) disable iff (!nrst)
    d_fault != '0 |-> (drive_on & d_fault) == '0)
    else $error("faulted channel still driven");

  chk_fault_latched: assert property (@(posedge clk) disable iff (!nrst)
    trip[0] ##1 !trip[0] && !clr[0] |-> d_fault[0] ##1 d_fault[0] || clr[0])
    else $error("overload fault not held");

  chk_so_window: assert property (@(posedge clk) disable iff (!nrst)
    !cs_n && cnt == '0 |-> so == (frame_error_flag | si) && so_oe)
    else $error("flag window output wrong");

endmodule

/* src/drvsp_sync.sv */
module drvsp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end

endmodule

/* verification/drvsp_master.sv */
module drvsp_master (
  // Serial link
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b1;
  end

  // ********
  // Frame of n bits, MSB first both ways
  // ********
  task automatic xfer(input int n, input logic [63:0] tx, input logic w,
                      output logic [63:0] rx, output logic f);
    rx = '0;
    si = w;
    #7.5 cs_n = 1'b0;
    #37.5 f = so;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b1;
      #1 si = tx[i];
      #6.5 rx[i] = so;
      sclk = 1'b0;
      #7.5;
    end
    #15 cs_n = 1'b1;
    si = ~si;
    #80;
  endtask

  // Clock and data wiggle while deselected
  task automatic noise;
    repeat (5) begin
      #7.5 sclk = 1'b1;
      si = ~si;
      #7.5 sclk = 1'b0;
    end
  endtask
endmodule

/* verification/drvsp_port_bench.sv */
module drvsp_port_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, nrst, sclk, cs_n, si, so, so_oe, flag, f;
  logic limp_home_input, uvlo_lock, low_quiescent_state;
  logic [7:0] ovl, otmp, olod, drive_on, shut;
  logic [15:0] input_word, fault_word;
  logic [63:0] rx;
  int failures, compares;
  logic so_line;

  // Deselected output shows the inverse so a sample outside the frame is caught
  assign so_line = so_oe ? so : ~so;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  drvsp_port DUT (
    .clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
    .so_oe(so_oe), .limp_home_input(limp_home_input), .uvlo_lock(uvlo_lock),
    .low_quiescent_state(low_quiescent_state), .overload_raw(ovl),
    .over_temp_raw(otmp), .open_load_raw(olod), .input_word(input_word),
    .drive_on(drive_on), .channel_shutdown(shut), .fault_word(fault_word),
    .frame_error_flag(flag)
  );

  drvsp_master m (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so_line));

  // ********
  // Helpers
  // ********
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic send(input int n, input logic [63:0] tx);
    m.xfer(n, tx, 1'b0, rx, f);
  endtask

  task automatic end_sim;
    $display("Counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_reset;
    check(input_word, 16'hFFFF);
    check(flag, 1'b1);
    check({drive_on, fault_word[7:0]}, 16'h0000);
    check(so_oe, 1'b0);
    send(0, 64'h0);
    check(f, 1'b1);
    check(flag, 1'b1);
    $display("Test reset done");
  endtask

  task automatic t_valid;
    send(16, 64'hAAAA);
    check(f, 1'b1);
    check(input_word, 16'hAAAA);
    check(drive_on, 8'hFF);
    check(rx[15:0], 16'h0000);
    check(flag, 1'b0);
    fork
      send(16, 64'hAAAA);
      begin
        #20;
        check(so_oe, 1'b1);
      end
    join
    check(f, 1'b0);
    $display("Test valid done");
  endtask

  task automatic t_bad;
    int lens[4] = '{15, 17, 8, 23};
    foreach (lens[i]) begin
      send(lens[i], 64'h5555);
      check(input_word, 16'hAAAA);
      check(flag, 1'b1);
    end
    m.noise;
    // Noise clocks must not count towards this eleven-bit frame
    send(11, 64'h5555);
    check(input_word, 16'hAAAA);
    check(flag, 1'b1);
    $display("Test bad length done");
  endtask

  task automatic t_long;
    send(24, 64'hC3AAA8);
    check(input_word, 16'hAAA8);
    check(rx[23:8], 16'h0000);
    check({8'h00, rx[7:0]}, 16'h00C3);
    check(drive_on, 8'hFE);
    send(32, 64'h0001AAAA);
    check(input_word, 16'hAAAA);
    check(rx[15:0], 16'h0001);
    m.xfer(16, 64'hAAAA, 1'b1, rx, f);
    check(f, 1'b1);
    send(16, 64'hAAAA);
    check(f, 1'b0);
    $display("Test long frame done");
  endtask

  task automatic t_fault;
    step(1);
    ovl = 8'h01;
    otmp = 8'h02;
    olod = 8'h80;
    step(250);
    check(shut, 8'h02);
    step(60);
    check(shut, 8'h03);
    check(drive_on, 8'hFC);
    ovl = 8'h00;
    otmp = 8'h00;
    olod = 8'h00;
    send(16, 64'hAAAA);
    check(rx[15:0], 16'h8005);
    check(drive_on, 8'hFC);
    send(16, 64'hAAA0);
    send(16, 64'hAAAA);
    check(drive_on, 8'hFF);
    check(fault_word, 16'h8000);
    $display("Test fault done");
  endtask

  task automatic t_mode;
    step(1);
    limp_home_input = 1'b1;
    otmp = 8'h04;
    step(4);
    send(16, 64'h5555);
    check(input_word, 16'hAAAA);
    check(rx[15:0], 16'h8010);
    check(shut, 8'h04);
    step(1);
    otmp = 8'h00;
    limp_home_input = 1'b0;
    step(6);
    check(input_word, 16'hFFFF);
    check(flag, 1'b1);
    for (int k = 0; k < 2; k++) begin
      send(16, 64'hAAAA);
      check(flag, 1'b0);
      step(1);
      uvlo_lock = (k == 0);
      low_quiescent_state = (k == 1);
      step(2);
      uvlo_lock = 1'b0;
      low_quiescent_state = 1'b0;
      step(3);
      check(flag, 1'b1);
    end
    $display("Test mode exit done");
  endtask

  initial begin
    nrst = 1'b0;
    limp_home_input = 1'b0;
    uvlo_lock = 1'b0;
    low_quiescent_state = 1'b0;
    ovl = 8'h00;
    otmp = 8'h00;
    olod = 8'h00;
    failures = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    step(3);
    t_reset;
    t_valid;
    t_bad;
    t_long;
    t_fault;
    t_mode;
    end_sim;
  end

  initial begin
    #200000;
    failures++;
    end_sim;
  end
endmodule
